/* design/sub_alu.sv */
// 8-bit subtractor producing the five arithmetic flags.
// Assumes operands held stable during the process quarter.
`timescale 1ns/1ps
`default_nettype none
`include "sub_datapath_consts.svh"
module sub_alu (
   input wire logic [7:0] minuend, // Left operand
   input wire logic [7:0] subtrahend, // Right operand
   input wire logic borrow_in, // High when a borrow is taken in
   output logic [7:0] diff, // Two's-complement result
   output logic [4:0] flags // N, OV, Z, DC, C
);
   // -----------------------------
   // Subtraction as add of complement
   // -----------------------------
   logic [8:0] full; // Ninth bit is not-borrow
   logic [4:0] low; // Low nibble with carry
   always_comb begin
      full = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, ~borrow_in};
      low = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, ~borrow_in};
      diff = full[7:0];
      flags = 5'h00;
      flags[`FLAG_C] = full[8]; // [RULE5] [RULE6] [RULE7]
      flags[`FLAG_DC] = low[4];
      flags[`FLAG_Z] = (full[7:0] == 8'h00); // [RULE6]
      flags[`FLAG_N] = full[7]; // [RULE7]
      flags[`FLAG_OV] = (minuend[7] != subtrahend[7]) && (full[7] != minuend[7]);
   end
endmodule // sub_alu
`default_nettype wire

/* design/sub_datapath.sv */
// Subtract instruction datapath with APB access to its registers.
// Assumes an APB master on pclk; file registers live in a local array.
`timescale 1ns/1ps
`default_nettype none
`include "sub_datapath_consts.svh"
// Behaviour
// [RULE1] Literal subtract computes literal minus accumulator
// [RULE2] Literal subtract always writes the accumulator
// [RULE3] Literal subtract: one word, four quarters
// [RULE4] File subtract: read Q2, process Q3, write Q4
// [RULE5] Positive result: carry set, zero and negative clear; the code takes negative from result bit 7
// [RULE6] Zero result: zero and carry set
// [RULE7] Underflow: wrap result, carry clear, negative set; the code takes negative from result bit 7
// [RULE8] File subtract computes file minus accumulator
// [RULE9] Destination bit zero selects accumulator
// [RULE10] Bank bit zero selects access bank
// [RULE11] Extended set, low address becomes indexed
module sub_datapath #(
   parameter int BANKS = 16 // Number of register banks
) (
   input wire logic pclk, // Core clock
   input wire logic presetn, // Asynchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   output logic busy // Instruction in flight
);
   // -----------------------------
   // State
   // -----------------------------
   sub_datapath_pkg::phase_t phase, next_phase; // Quarter phase
   sub_datapath_pkg::op_t op, next_op; // Decoded kind
   logic [15:0] instr, next_instr; // Instruction word
   logic [7:0] acc, next_acc; // Accumulator
   logic [4:0] status, next_status; // Arithmetic flags
   logic [3:0] bank_sel, next_bank_sel; // Bank select register
   logic ext_en, next_ext_en; // Extended set enable
   logic [7:0] fsr_base, next_fsr_base; // Index base for literal offset
   logic [7:0] opnd, next_opnd; // Operand read in Q2
   logic [7:0] res, next_res; // Result from Q3
   logic [4:0] res_flags, next_res_flags; // Flags from Q3
   logic [11:0] eff, next_eff; // Effective file address
   logic [7:0] file_mem [BANKS*256]; // Data memory
   logic [7:0] alu_min, alu_sub, alu_diff; // ALU ports
   logic alu_bin; // Borrow into ALU
   logic [4:0] alu_flags; // ALU flags
   logic apb_wr, apb_acc, mapped, file_hit; // Bus decode
   logic mem_we; // Data memory write strobe
   logic [11:0] mem_addr; // Data memory write address
   logic [7:0] mem_wdata; // Data memory write data

   // Effective address from bank bit, bank select and index mode
   function automatic logic [11:0] file_addr(input logic [15:0] w, input logic [3:0] bs,
                                             input logic ext, input logic [7:0] base);
      logic [7:0] f;
      f = w[7:0];
      if (!w[`BANK_BIT] && ext && f <= `INDEX_LIMIT) // [RULE11]
         file_addr = {4'h0, 8'(base + f)};
      else if (!w[`BANK_BIT]) // [RULE10]
         file_addr = f[7] ? {4'hf, f} : {4'h0, f};
      else
         file_addr = {bs, f}; // [RULE10]
   endfunction

   // -----------------------------
   // APB decode
   // -----------------------------
   always_comb begin
      busy = phase != sub_datapath_pkg::q_idle; // Set first: pready below reads it
      apb_acc = psel && penable;
      apb_wr = apb_acc && pwrite;
      file_hit = paddr >= `ADDR_FILE_BASE;
      mapped = file_hit || paddr == `ADDR_INSTR || paddr == `ADDR_ACC ||
               paddr == `ADDR_STATUS || paddr == `ADDR_BANK || paddr == `ADDR_CTRL;
      pready = !(busy && paddr == `ADDR_INSTR && pwrite); // Instruction waits for idle
      pslverr = apb_acc && !mapped;
   end

   // Read data from flip-flops of block state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            `ADDR_INSTR: prdata <= {16'h0000, instr};
            `ADDR_ACC: prdata <= {24'h000000, acc};
            `ADDR_STATUS: prdata <= {27'h0000000, status};
            `ADDR_BANK: prdata <= {28'h0000000, bank_sel};
            `ADDR_CTRL: prdata <= {23'h000000, fsr_base, ext_en};
            default: prdata <= file_hit ? {24'h000000, file_mem[{1'b0, paddr[10:0]} >> 2]} : 32'h0000_0000;
         endcase
      end
   end

   // -----------------------------
   // ALU
   // -----------------------------
   always_comb begin
      alu_min = opnd; // [RULE8]
      alu_sub = acc;
      alu_bin = 1'b0;
      unique case (op)
         sub_datapath_pkg::op_lit: alu_min = instr[7:0]; // [RULE1]
         sub_datapath_pkg::op_file_borrow: alu_bin = !status[`FLAG_C];
         sub_datapath_pkg::op_acc_borrow: begin
            alu_min = acc;
            alu_sub = opnd;
            alu_bin = !status[`FLAG_C];
         end
         default: ;
      endcase
   end

   sub_alu u_alu (
      .minuend(alu_min),
      .subtrahend(alu_sub),
      .borrow_in(alu_bin),
      .diff(alu_diff),
      .flags(alu_flags)
   );

   // -----------------------------
   // Quarter sequencer and registers
   // -----------------------------
   always_comb begin
      next_phase = phase;
      next_op = op;
      next_instr = instr;
      next_acc = acc;
      next_status = status;
      next_bank_sel = bank_sel;
      next_ext_en = ext_en;
      next_fsr_base = fsr_base;
      next_opnd = opnd;
      next_res = res;
      next_res_flags = res_flags;
      next_eff = eff;
      mem_we = 1'b0;
      mem_addr = 12'h000;
      mem_wdata = 8'h00;
      if (apb_wr && !busy) begin
         unique case (paddr)
            `ADDR_INSTR: begin
               next_instr = pwdata[15:0];
               next_phase = sub_datapath_pkg::q_decode;
            end
            `ADDR_ACC: next_acc = pwdata[7:0];
            `ADDR_STATUS: next_status = pwdata[4:0];
            `ADDR_BANK: next_bank_sel = pwdata[3:0];
            `ADDR_CTRL: begin
               next_ext_en = pwdata[0];
               next_fsr_base = pwdata[8:1];
            end
            default: begin
               mem_we = file_hit;
               mem_addr = {1'b0, paddr[10:0]} >> 2;
               mem_wdata = pwdata[7:0];
            end
         endcase
      end
      unique case (phase)
         sub_datapath_pkg::q_idle: ;
         sub_datapath_pkg::q_decode: begin // [RULE3]
            next_op = sub_datapath_pkg::op_none;
            if (instr[15:8] == `OP_LIT_HI)
               next_op = sub_datapath_pkg::op_lit;
            else if (instr[15:10] == `OP_FILE_HI6)
               next_op = sub_datapath_pkg::op_file;
            else if (instr[15:10] == `OP_FILE_BORROW_HI6)
               next_op = sub_datapath_pkg::op_acc_borrow;
            else if (instr[15:10] == `OP_WFB_HI6)
               next_op = sub_datapath_pkg::op_file_borrow;
            next_eff = file_addr(instr, bank_sel, ext_en, fsr_base);
            next_phase = sub_datapath_pkg::q_read;
         end
         sub_datapath_pkg::q_read: begin // [RULE4]
            next_opnd = file_mem[eff];
            next_phase = sub_datapath_pkg::q_process;
         end
         sub_datapath_pkg::q_process: begin // [RULE4]
            next_res = alu_diff;
            next_res_flags = alu_flags;
            next_phase = sub_datapath_pkg::q_write;
         end
         sub_datapath_pkg::q_write: begin
            if (op != sub_datapath_pkg::op_none) begin
               next_status = res_flags;
               if (op == sub_datapath_pkg::op_lit || !instr[`DEST_BIT]) // [RULE2] [RULE9]
                  next_acc = res;
               else begin
                  mem_we = 1'b1; // [RULE9]
                  mem_addr = eff;
                  mem_wdata = res;
               end
            end
            next_phase = sub_datapath_pkg::q_idle;
         end
         default: next_phase = sub_datapath_pkg::q_idle;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= sub_datapath_pkg::q_idle;
         op <= sub_datapath_pkg::op_none;
         instr <= 16'h0000;
         acc <= `ACC_RESET;
         status <= `STATUS_RESET;
         bank_sel <= `BANK_RESET;
         ext_en <= `EXT_RESET;
         fsr_base <= 8'h00;
         opnd <= 8'h00;
         res <= 8'h00;
         res_flags <= 5'h00;
         eff <= 12'h000;
      end else begin
         phase <= next_phase;
         op <= next_op;
         instr <= next_instr;
         acc <= next_acc;
         status <= next_status;
         bank_sel <= next_bank_sel;
         ext_en <= next_ext_en;
         fsr_base <= next_fsr_base;
         opnd <= next_opnd;
         res <= next_res;
         res_flags <= next_res_flags;
         eff <= next_eff;
      end
   end

   // Data memory has no reset
   always_ff @(posedge pclk) begin
      if (mem_we)
         file_mem[mem_addr] <= mem_wdata;
   end

   // -----------------------------
   // Assertions
   // -----------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_four_quarters: assert property (phase == sub_datapath_pkg::q_decode |=> // [RULE3]
      ##2 phase == sub_datapath_pkg::q_write ##1 phase == sub_datapath_pkg::q_idle)
      else $error("cycle not four quarters");
   a_lit_value: assert property (phase == sub_datapath_pkg::q_write && op == sub_datapath_pkg::op_lit // [RULE2]
      |=> acc == $past(res))
      else $error("literal result not in acc");
   a_lit_calc: assert property (phase == sub_datapath_pkg::q_process && op == sub_datapath_pkg::op_lit // [RULE1]
      |=> res == 8'(instr[7:0] - acc))
      else $error("literal minus acc wrong");
   a_file_calc: assert property (phase == sub_datapath_pkg::q_process && op == sub_datapath_pkg::op_file // [RULE8]
      |=> res == 8'(opnd - acc))
      else $error("file minus acc wrong");
   a_file_read: assert property (phase == sub_datapath_pkg::q_read // [RULE4]
      |=> opnd == $past(file_mem[eff]))
      else $error("operand not read in Q2");
   a_positive: assert property (phase == sub_datapath_pkg::q_process && op == sub_datapath_pkg::op_file // [RULE5]
      && opnd > acc |=> res_flags[`FLAG_C] && !res_flags[`FLAG_Z])
      else $error("positive flags wrong");
   a_zero: assert property (phase == sub_datapath_pkg::q_process && op == sub_datapath_pkg::op_file // [RULE6]
      && opnd == acc |=> res_flags[`FLAG_Z] && res_flags[`FLAG_C] && !res_flags[`FLAG_N])
      else $error("zero flags wrong");
   a_underflow: assert property (phase == sub_datapath_pkg::q_process && op == sub_datapath_pkg::op_file // [RULE7]
      && opnd < acc |=> !res_flags[`FLAG_C] && !res_flags[`FLAG_Z])
      else $error("borrow flags wrong");
   a_dest_acc: assert property (phase == sub_datapath_pkg::q_write && op == sub_datapath_pkg::op_file // [RULE9]
      && !instr[`DEST_BIT] |-> !mem_we)
      else $error("dest zero wrote file");
   a_access_bank: assert property (phase == sub_datapath_pkg::q_decode && !instr[`BANK_BIT] // [RULE10]
      && !ext_en && !instr[7] |=> eff[11:8] == 4'h0)
      else $error("access bank wrong");
   a_indexed: assert property (phase == sub_datapath_pkg::q_decode && !instr[`BANK_BIT] // [RULE11]
      && ext_en && instr[7:0] <= `INDEX_LIMIT
      |=> eff == {4'h0, 8'($past(fsr_base) + $past(instr[7:0]))})
      else $error("indexed address wrong");
   c_lit: cover property (phase == sub_datapath_pkg::q_write && op == sub_datapath_pkg::op_lit);
   c_file_dest: cover property (phase == sub_datapath_pkg::q_write && op == sub_datapath_pkg::op_file
      && instr[`DEST_BIT]);
   c_borrow: cover property (phase == sub_datapath_pkg::q_write && !res_flags[`FLAG_C]);
endmodule // sub_datapath
`default_nettype wire

/* design/sub_datapath_consts.svh */
// Constants of the subtract datapath: opcode fields, flag bits, reset values, APB map.
// Assumes inclusion by bare name from the design files.
`ifndef SUB_DATAPATH_CONSTS_SVH
`define SUB_DATAPATH_CONSTS_SVH
// -----------------------------
// Opcode patterns
// -----------------------------
`define OP_LIT_HI 8'h08
`define OP_FILE_HI6 6'h17
`define OP_FILE_BORROW_HI6 6'h15
`define OP_WFB_HI6 6'h16
`define DEST_BIT 9
`define BANK_BIT 8
`define INDEX_LIMIT 8'h5f
// -----------------------------
// Status flag positions
// -----------------------------
`define FLAG_C 0
`define FLAG_DC 1
`define FLAG_Z 2
`define FLAG_OV 3
`define FLAG_N 4
// -----------------------------
// Register reset values
// -----------------------------
`define ACC_RESET 8'h00
`define STATUS_RESET 5'h00
`define BANK_RESET 4'h0
`define EXT_RESET 1'b0
// -----------------------------
// APB map (byte addresses)
// -----------------------------
`define ADDR_INSTR 12'h000
`define ADDR_ACC 12'h004
`define ADDR_STATUS 12'h008
`define ADDR_BANK 12'h00c
`define ADDR_CTRL 12'h010
`define ADDR_FILE_BASE 12'h800
`endif

/* design/sub_datapath_pkg.sv */
// Types of the subtract datapath: quarter phase and operation kind.
// Assumes nothing of its surroundings.
`default_nettype none
package sub_datapath_pkg;
   // Quarter-cycle phase of one instruction cycle
   typedef enum logic [2:0] {
      q_idle = 3'b000,
      q_decode = 3'b001,
      q_read = 3'b010,
      q_process = 3'b011,
      q_write = 3'b100
   } phase_t;
   // Decoded operation kind
   typedef enum logic [2:0] {
      op_none = 3'b000,
      op_lit = 3'b001,
      op_file = 3'b010,
      op_file_borrow = 3'b011,
      op_acc_borrow = 3'b100
   } op_t;
endpackage
`default_nettype wire

/* test/test_sub_datapath.sv */
// Self-checking bench of the subtract datapath, driven over APB.
// Assumes the design files and the constants header are on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "sub_datapath_consts.svh"
module test_sub_datapath;
   // ----------------------------------------
   // Clock, reset, bus and bookkeeping
   // ----------------------------------------
   logic pclk; // Core clock, 100 MHz
   logic presetn; // Reset, active low
   logic psel; // APB select
   logic penable; // APB access phase
   logic pwrite; // APB direction
   logic [11:0] paddr; // APB byte address
   logic [31:0] pwdata; // APB write data
   logic [31:0] prdata; // APB read data
   logic pready; // APB ready
   logic pslverr; // APB error
   logic busy; // Instruction in flight
   logic [31:0] q_data; // Data of the last transfer
   logic q_err; // Error of the last transfer
   int q_waits = 0; // Wait states of the last transfer
   logic [31:0] seed = 32'h8231; // Random state, fixed start
   int n_fail = 0; // Mismatches seen
   int cmp_count = 0; // Comparisons made
   int cyc = 0; // Cycles since start
   sub_datapath #(.BANKS(16)) sub_datapath_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .busy(busy));
   // Clock toggles every half period
   always #5 pclk = ~pclk;
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Xorshift step of the random state
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Status expected after a minus b minus borrow: {N, OV, Z, DC, C}
   function automatic logic [31:0] exp_status(input logic [7:0] a, input logic [7:0] b, input logic bin);
      logic [7:0] r;
      r = a - b - {7'h00, bin};
      return {27'h0, r[7], (a[7] != b[7]) && (r[7] != a[7]), r == 8'h00,
              {1'b0, a[3:0]} >= {1'b0, b[3:0]} + {4'h0, bin}, {1'b0, a} >= {1'b0, b} + {8'h00, bin}};
   endfunction
   // Compares one value and counts it
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Prints the verdict and stops
   task automatic complete_run();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // One APB transfer; holds the request until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      q_waits = 0;
      while (pready !== 1'b1) begin
         q_waits++;
         @(posedge pclk);
      end
      q_data = prdata;
      q_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Issues one instruction and follows busy through its four quarters
   task automatic run_instr(input logic [15:0] ins);
      apb(1'b1, `ADDR_INSTR, {16'h0, ins});
      for (int i = 0; i < 5; i++) begin
         @(negedge pclk);
         check("busy", {31'h0, busy}, {31'h0, i < 4});
      end
   endtask
   // Literal subtract from a preset accumulator
   task automatic lit(input logic [7:0] acc0, input logic [7:0] k);
      apb(1'b1, `ADDR_ACC, {24'h0, acc0});
      run_instr({`OP_LIT_HI, k});
      apb(1'b0, `ADDR_ACC, 32'h0);
      check("acc lit", q_data, {24'h0, k - acc0});
      apb(1'b0, `ADDR_STATUS, 32'h0);
      check("status lit", q_data, exp_status(k, acc0, 1'b0));
   endtask
   // A hang counts as a mismatch
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         complete_run();
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [31:0] r; // Random draw
      logic [7:0] f; // File address
      logic [8:0] n; // Linear file index
      logic [7:0] fv; // File operand
      logic [7:0] av; // Accumulator operand
      logic [11:0] fa; // File byte address
      logic [7:0] mn; // Borrow minuend
      logic [7:0] sb; // Borrow subtrahend
      logic [7:0] rs; // Borrow result expected
      logic bin_c; // Borrow taken in
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values of the accumulator, status and bank registers
      apb(1'b0, `ADDR_ACC, 32'h0);
      check("acc reset", q_data, 32'h0);
      apb(1'b0, `ADDR_STATUS, 32'h0);
      check("status reset", q_data, 32'h0);
      apb(1'b0, `ADDR_BANK, 32'h0);
      check("bank reset", q_data, 32'h0);
      // Unmapped place answers with an error and zero data
      apb(1'b0, 12'h014, 32'h0);
      check("unmapped err", {31'h0, q_err}, 32'h1);
      check("unmapped data", q_data, 32'h0);
      // Literal corners: positive, zero, negative, overflow, then random
      lit(8'h01, 8'h02);
      lit(8'h02, 8'h02);
      lit(8'h03, 8'h02);
      lit(8'h01, 8'h80);
      lit(8'hff, 8'h00);
      for (int i = 0; i < 20; i++) begin
         r = rnd();
         lit(r[7:0], r[15:8]);
      end
      // Back-to-back: second write waits until the first has finished
      apb(1'b1, `ADDR_ACC, 32'h10);
      apb(1'b1, `ADDR_INSTR, {16'h0, `OP_LIT_HI, 8'h30});
      run_instr({`OP_LIT_HI, 8'h05});
      // Bench pacing puts the access phase at the process quarter: two waits
      check("instr waits", q_waits, 32'h2);
      apb(1'b0, `ADDR_ACC, 32'h0);
      check("acc chain", q_data, 32'he5);
      // An accumulator write while an instruction runs is ignored
      apb(1'b1, `ADDR_INSTR, {16'h0, `OP_LIT_HI, 8'h30});
      apb(1'b1, `ADDR_ACC, 32'haa);
      apb(1'b0, `ADDR_ACC, 32'h0);
      check("acc refused", q_data, 32'h4b);
      // File minus accumulator over random destination, bank bit and bank
      for (int i = 0; i < 16; i++) begin
         r = rnd();
         f = {1'b0, r[6:0]};
         fv = r[23:16];
         av = r[31:24];
         n = r[8] ? {r[9], f} : {1'b0, f};
         fa = `ADDR_FILE_BASE + {1'b0, n, 2'b00};
         apb(1'b1, `ADDR_BANK, {31'h0, r[9]});
         apb(1'b1, `ADDR_ACC, {24'h0, av});
         apb(1'b1, fa, {24'h0, fv});
         run_instr({`OP_FILE_HI6, r[7], r[8], f});
         apb(1'b0, `ADDR_ACC, 32'h0);
         check("acc file", q_data, {24'h0, r[7] ? av : fv - av});
         apb(1'b0, fa, 32'h0);
         check("file dest", q_data, {24'h0, r[7] ? fv - av : fv});
         apb(1'b0, `ADDR_STATUS, 32'h0);
         check("status file", q_data, exp_status(fv, av, 1'b0));
      end
      // Borrow variants: two hand corners, then random carry, order and destination
      for (int i = 0; i < 10; i++) begin
         r = (i == 0) ? 32'h0005_0203 : (i == 1) ? 32'h0007_0d19 : rnd();
         fv = r[7:0];
         av = r[15:8];
         bin_c = !r[16];
         mn = r[17] ? fv : av;
         sb = r[17] ? av : fv;
         rs = mn - sb - {7'h00, bin_c};
         apb(1'b1, `ADDR_STATUS, {31'h0, r[16]});
         apb(1'b1, `ADDR_ACC, {24'h0, av});
         apb(1'b1, `ADDR_FILE_BASE + 12'h004, {24'h0, fv});
         run_instr({r[17] ? `OP_WFB_HI6 : `OP_FILE_BORROW_HI6, r[18], 1'b0, 8'h01});
         apb(1'b0, `ADDR_ACC, 32'h0);
         check("acc borrow", q_data, {24'h0, r[18] ? av : rs});
         apb(1'b0, `ADDR_FILE_BASE + 12'h004, 32'h0);
         check("file borrow", q_data, {24'h0, r[18] ? rs : fv});
         apb(1'b0, `ADDR_STATUS, 32'h0);
         check("status borrow", q_data, exp_status(mn, sb, bin_c));
      end
      // Indexed mode: base 0x20 plus address 0x10 reaches byte 0x30
      apb(1'b1, `ADDR_CTRL, 32'h41);
      apb(1'b1, `ADDR_FILE_BASE + 12'h0c0, 32'h50);
      apb(1'b1, `ADDR_ACC, 32'h10);
      run_instr({`OP_FILE_HI6, 1'b1, 1'b0, 8'h10});
      apb(1'b0, `ADDR_FILE_BASE + 12'h0c0, 32'h0);
      check("indexed file", q_data, 32'h40);
      complete_run();
   end
endmodule // test_sub_datapath
`default_nettype wire
